// *** rtl/serial_image_uploader.v ***
/*
  Serial image uploader: receives an image over the debug serial port
  (CRC Xmodem) or as a byte stream from a USB firmware-upgrade engine,
  writes it to SRAM and then hands control to it via the remap sequence.
  Assumes the USB engine and SRAM sit outside; inputs are synchronous.
*/
`timescale 1ns/1ps
`include "uploader_map.vh"
`default_nettype none
module serial_image_uploader #(
  parameter integer BIT_CYCLES = `BIT_CYCLES,
  parameter integer PIN_DRIVE_CYCLES = `PIN_DRIVE_CYCLES,
  parameter integer SRAM_BYTES = `SRAM_BYTES
) (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Boot search result and clocks
  input wire boot_done_i,
  input wire boot_valid_i,
  input wire usb_clk_ok_i,
  // Debug serial port
  input wire rxd_i,
  output wire txd_o,
  // USB upgrade engine byte stream
  input wire [1:0] usb_phase_i,
  input wire usb_valid_i,
  input wire [7:0] usb_data_i,
  output wire usb_ready_o,
  input wire usb_last_i,
  output wire usb_manifest_done_o,
  input wire usb_host_reset_i,
  // SRAM write port
  output wire mem_we_o,
  output wire [31:0] mem_addr_o,
  output wire [7:0] mem_data_o,
  input wire mem_ready_i,
  // Status and hand-off
  output wire boot_pins_drive_o,
  output wire channels_on_o,
  output wire usb_on_o,
  output wire periph_reset_o,
  output wire irq_disable_o,
  output wire remap_o,
  output wire jump_zero_o,
  output wire too_big_o
);
  localparam [1:0] PH_TRANSFER = 2'd2;
  localparam [1:0] PH_MANIFEST = 2'd3;
  localparam [31:0] LIMIT = SRAM_BYTES - `RESERVE_BYTES;
  // Top control
  localparam [2:0] T_WAIT = 3'b000;
  localparam [2:0] T_PINS = 3'b001;
  localparam [2:0] T_RUN = 3'b010;
  localparam [2:0] T_RST = 3'b011;
  localparam [2:0] T_IRQ = 3'b100;
  localparam [2:0] T_JUMP = 3'b101;
  localparam [2:0] T_REMAP = 3'b110;
  localparam [2:0] T_DONE = 3'b111;
  reg [2:0] top_reg;
  reg [22:0] cnt_reg;
  // Hand-off flags stay set until reset
  reg periph_reg;
  reg irq_reg;
  reg remap_reg;
  reg jump_reg;
  reg big_reg;
  wire image_done;
  assign boot_pins_drive_o = (top_reg == T_PINS);
  assign channels_on_o = (top_reg == T_RUN);
  assign usb_on_o = channels_on_o && usb_clk_ok_i;
  assign periph_reset_o = periph_reg;
  assign irq_disable_o = irq_reg;
  assign remap_o = remap_reg;
  assign jump_zero_o = jump_reg;
  assign too_big_o = big_reg;
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      top_reg <= T_WAIT;
      cnt_reg <= 23'h000000;
      periph_reg <= 1'b0;
      irq_reg <= 1'b0;
      remap_reg <= 1'b0;
      jump_reg <= 1'b0;
    end else begin
      case (top_reg)
        T_WAIT: if (boot_done_i && !boot_valid_i) begin
          top_reg <= T_PINS;
          cnt_reg <= 23'h000000;
        end
        T_PINS: begin
          cnt_reg <= cnt_reg + 23'h000001;
          if (cnt_reg == PIN_DRIVE_CYCLES - 1) top_reg <= T_RUN;
        end
        T_RUN: if (image_done) top_reg <= T_RST;
        T_RST: begin
          periph_reg <= 1'b1;
          top_reg <= T_IRQ;
        end
        T_IRQ: begin
          irq_reg <= 1'b1;
          top_reg <= T_JUMP;
        end
        T_JUMP: begin
          jump_reg <= 1'b1;
          top_reg <= T_REMAP;
        end
        T_REMAP: begin
          remap_reg <= 1'b1;
          top_reg <= T_DONE;
        end
        T_DONE: top_reg <= T_DONE;
        default: top_reg <= T_WAIT;
      endcase
    end
  end

  // Serial receiver, 8N1
  reg [1:0] rx_st_reg;
  reg [9:0] rx_cnt_reg;
  reg [2:0] rx_bit_reg;
  reg [7:0] rx_sh_reg;
  reg rx_stb_reg;
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rx_st_reg <= 2'd0;
      rx_cnt_reg <= 10'h000;
      rx_bit_reg <= 3'd0;
      rx_sh_reg <= 8'h00;
      rx_stb_reg <= 1'b0;
    end else begin
      rx_stb_reg <= 1'b0;
      case (rx_st_reg)
        2'd0: if (!rxd_i && channels_on_o) begin
          rx_st_reg <= 2'd1;
          rx_cnt_reg <= 10'h000;
        end
        2'd1: if (rx_cnt_reg == BIT_CYCLES / 2) begin
          rx_cnt_reg <= 10'h000;
          rx_bit_reg <= 3'd0;
          rx_st_reg <= rxd_i ? 2'd0 : 2'd2;
        end else rx_cnt_reg <= rx_cnt_reg + 10'h001;
        2'd2: if (rx_cnt_reg == BIT_CYCLES - 1) begin
          rx_cnt_reg <= 10'h000;
          rx_sh_reg <= {rxd_i, rx_sh_reg[7:1]};
          rx_bit_reg <= rx_bit_reg + 3'd1;
          if (rx_bit_reg == 3'd7) rx_st_reg <= 2'd3;
        end else rx_cnt_reg <= rx_cnt_reg + 10'h001;
        2'd3: if (rx_cnt_reg == BIT_CYCLES - 1) begin
          rx_st_reg <= 2'd0;
          rx_stb_reg <= rxd_i;
        end else rx_cnt_reg <= rx_cnt_reg + 10'h001;
        default: rx_st_reg <= 2'd0;
      endcase
    end
  end

  // Serial transmitter, 8N1
  reg [9:0] tx_cnt_reg;
  reg [3:0] tx_bit_reg;
  reg [9:0] tx_sh_reg;
  reg tx_busy_reg;
  reg tx_go;
  reg [7:0] tx_byte;
  assign txd_o = tx_busy_reg ? tx_sh_reg[0] : 1'b1;
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      tx_cnt_reg <= 10'h000;
      tx_bit_reg <= 4'h0;
      tx_sh_reg <= 10'h3FF;
      tx_busy_reg <= 1'b0;
    end else if (!tx_busy_reg) begin
      if (tx_go) begin
        tx_sh_reg <= {1'b1, tx_byte, 1'b0};
        tx_busy_reg <= 1'b1;
        tx_cnt_reg <= 10'h000;
        tx_bit_reg <= 4'h0;
      end
    end else if (tx_cnt_reg == BIT_CYCLES - 1) begin
      tx_cnt_reg <= 10'h000;
      tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
      tx_bit_reg <= tx_bit_reg + 4'h1;
      if (tx_bit_reg == 4'h9) tx_busy_reg <= 1'b0;
    end else tx_cnt_reg <= tx_cnt_reg + 10'h001;
  end

  // Xmodem block parser
  localparam [2:0] X_IDLE = 3'b000;
  localparam [2:0] X_NUM = 3'b001;
  localparam [2:0] X_CPL = 3'b010;
  localparam [2:0] X_DATA = 3'b011;
  localparam [2:0] X_CRCH = 3'b100;
  localparam [2:0] X_CRCL = 3'b101;
  localparam [2:0] X_END = 3'b110;
  reg [2:0] x_reg;
  reg [7:0] blk_reg;
  reg [7:0] num_reg;
  reg [7:0] crch_reg;
  reg [7:0] idx_reg;
  reg [15:0] crc_reg;
  reg cpl_ok_reg;
  reg x_done_reg;
  reg invite_reg;
  // Idle counter wraps after 2^24 cycles, so the invite repeats that rarely
  reg [23:0] idle_reg;
  reg [7:0] reply_reg;
  reg reply_pend_reg;
  reg [15:0] crc_next;
  integer i;
  always @* begin
    crc_next = crc_reg ^ {rx_sh_reg, 8'h00};
    for (i = 0; i < 8; i = i + 1) begin
      crc_next = crc_next[15] ? ((crc_next << 1) ^ `CRC_POLY) : (crc_next << 1);
    end
  end
  // Buffer toward SRAM: two entries
  reg [7:0] buf_d_reg [0:1];
  reg [1:0] buf_n_reg;
  reg buf_wp_reg, buf_rp_reg;
  wire buf_full = (buf_n_reg == 2'd2);
  wire x_push = (x_reg == X_DATA) && rx_stb_reg && !buf_full;
  wire x_busy = (x_reg != X_IDLE) && (x_reg != X_END);
  // USB stream locked out while a serial block is in flight
  wire from_usb = !x_busy && usb_phase_i == PH_TRANSFER;
  assign usb_ready_o = from_usb && !buf_full && usb_on_o;
  wire u_push = usb_valid_i && usb_ready_o;
  wire push = x_push || u_push;
  wire [7:0] push_d = x_push ? rx_sh_reg : usb_data_i;
  wire pop = (buf_n_reg != 2'd0) && mem_ready_i;
  reg [31:0] addr_reg;
  always @* begin
    tx_go = 1'b0;
    tx_byte = reply_reg;
    if (reply_pend_reg) tx_go = 1'b1;
    else if (invite_reg) begin
      tx_go = 1'b1;
      tx_byte = `CHR_INVITE;
    end
  end
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      x_reg <= X_IDLE;
      blk_reg <= `FIRST_BLOCK;
      num_reg <= 8'h00;
      crch_reg <= 8'h00;
      idx_reg <= 8'h00;
      crc_reg <= `CRC_INIT;
      cpl_ok_reg <= 1'b0;
      x_done_reg <= 1'b0;
      invite_reg <= 1'b0;
      idle_reg <= 24'h000000;
      reply_reg <= 8'h00;
      reply_pend_reg <= 1'b0;
    end else begin
      if (tx_go && !tx_busy_reg) begin
        reply_pend_reg <= 1'b0;
        invite_reg <= 1'b0;
      end
      if (x_reg == X_IDLE && channels_on_o && !x_done_reg && blk_reg == `FIRST_BLOCK
          && !tx_busy_reg && !reply_pend_reg) begin
        idle_reg <= idle_reg + 24'h000001;
        if (idle_reg == 24'h000000) invite_reg <= 1'b1;
      end
      if (rx_stb_reg) begin
        idle_reg <= 24'h000001;
        case (x_reg)
          X_IDLE: if (rx_sh_reg == `CHR_SOH) x_reg <= X_NUM;
            else if (rx_sh_reg == `CHR_EOT && blk_reg != `FIRST_BLOCK) begin
              reply_reg <= `CHR_ACK;
              reply_pend_reg <= 1'b1;
              x_done_reg <= 1'b1;
              x_reg <= X_END;
            end
          X_NUM: begin
            num_reg <= rx_sh_reg;
            x_reg <= X_CPL;
          end
          X_CPL: begin
            cpl_ok_reg <= (rx_sh_reg == ~num_reg) && (num_reg == blk_reg);
            idx_reg <= 8'h00;
            crc_reg <= `CRC_INIT;
            x_reg <= X_DATA;
          end
          X_DATA: if (!buf_full) begin
            crc_reg <= crc_next;
            idx_reg <= idx_reg + 8'h01;
            if (idx_reg == `BLOCK_BYTES - 1) x_reg <= X_CRCH;
          end
          X_CRCH: begin
            crch_reg <= rx_sh_reg;
            x_reg <= X_CRCL;
          end
          X_CRCL: begin
            x_reg <= X_IDLE;
            reply_pend_reg <= 1'b1;
            if (cpl_ok_reg && {crch_reg, rx_sh_reg} == crc_reg) begin
              reply_reg <= `CHR_ACK;
              blk_reg <= blk_reg + 8'h01;
            end else begin
              reply_reg <= `CHR_NAK;
            end
          end
          default: x_reg <= x_reg;
        endcase
      end
    end
  end
  // Rewind address on a rejected block if the buffer is empty at its last CRC byte, so a retransmission overwrites it
  reg [31:0] blk_addr_reg;
  reg usb_done_reg;
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      buf_n_reg <= 2'd0;
      buf_wp_reg <= 1'b0;
      buf_rp_reg <= 1'b0;
      addr_reg <= `SRAM_LOAD_BASE;
      blk_addr_reg <= `SRAM_LOAD_BASE;
      big_reg <= 1'b0;
      usb_done_reg <= 1'b0;
    end else begin
      if (push) begin
        buf_d_reg[buf_wp_reg] <= push_d;
        buf_wp_reg <= ~buf_wp_reg;
      end
      if (pop) begin
        buf_rp_reg <= ~buf_rp_reg;
        addr_reg <= addr_reg + 32'h0000_0001;
        if (addr_reg - `SRAM_LOAD_BASE >= LIMIT - 1) big_reg <= 1'b1;
      end
      buf_n_reg <= buf_n_reg + {1'b0, push} - {1'b0, pop};
      if (rx_stb_reg && x_reg == X_CRCL) begin
        if (cpl_ok_reg && {crch_reg, rx_sh_reg} == crc_reg)
          blk_addr_reg <= blk_addr_reg + `BLOCK_BYTES;
        // Two CRC byte times leave the buffer drained unless memory stalls
        else if (buf_n_reg == 2'd0) addr_reg <= blk_addr_reg;
      end
      if (u_push && usb_last_i) usb_done_reg <= 1'b1;
    end
  end
  assign mem_we_o = pop && !big_reg;
  assign mem_addr_o = addr_reg;
  assign mem_data_o = buf_d_reg[buf_rp_reg];
  // Manifestation reported once the last byte is in SRAM
  assign usb_manifest_done_o = usb_done_reg && buf_n_reg == 2'd0 &&
    usb_phase_i == PH_MANIFEST;
  assign image_done = buf_n_reg == 2'd0 && !tx_busy_reg && !reply_pend_reg &&
    (x_done_reg || (usb_manifest_done_o && usb_host_reset_i));
endmodule
`default_nettype wire

// *** rtl/uploader_map.vh ***
/*
  Constants for the serial image uploader: protocol bytes, memory
  addresses, serial timing and size limits.
  Assumes a 40 MHz system clock and Verilog-2005 includers.
*/
// Notes on behaviour
// - Serial and USB upload channels start only when boot search found nothing.
// - Debug serial link runs 115200 baud, eight data bits, no parity, one stop.
// - Device invites a transfer by sending character C, 0x43.
// - Block is SOH 01, number, complement, 128 data bytes, then check field.
// - Block number starts at 01, increments, wraps from FF to 00.
// - Byte after block number must be its ones' complement; receiver checks.
// - Two-byte CRC-16 over data closes each block; receiver checks it.
// - Image bytes from either channel stored sequentially from 0x0020_0000.
// - After image: reset peripherals and pins, disable interrupts, then remap.
// - After remap SRAM decodes at zero and ROM at 0x0010_0000.
// - Jump to zero fetched before remap, executed after it.
// - USB channel starts only once the 48 MHz USB clock runs.
// - USB upgrade goes enumeration, reconfiguration, transfer, manifestation in order.
// - After manifestation complete the host resets; device then runs new firmware.
// - Boot-memory pins driven about 6 ms before the uploader takes over.
`ifndef UPLOADER_MAP_VH
`define UPLOADER_MAP_VH
`define CLK_HZ 40000000
`define BAUD_RATE 115200
`define BIT_CYCLES (`CLK_HZ / `BAUD_RATE)
`define PIN_DRIVE_MS 6
`define PIN_DRIVE_CYCLES (`CLK_HZ / 1000 * `PIN_DRIVE_MS)
`define CHR_SOH 8'h01
`define CHR_EOT 8'h04
`define CHR_ACK 8'h06
`define CHR_NAK 8'h15
`define CHR_INVITE 8'h43
`define BLOCK_BYTES 128
`define FIRST_BLOCK 8'h01
`define CRC_POLY 16'h1021
`define CRC_INIT 16'h0000
`define SRAM_LOAD_BASE 32'h0020_0000
`define SRAM_REMAP_BASE 32'h0000_0000
`define ROM_REMAP_BASE 32'h0010_0000
`define SRAM_BYTES 16384
`define RESERVE_BYTES 4096
`endif

// *** verif/serial_image_uploader_chk.sv ***
/* Port checker for serial_image_uploader.
   Bound by module name; one clock domain with synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module serial_image_uploader_chk #(parameter integer SRAM_BYTES = 16384) (
  // Clock, reset and inputs
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic boot_valid_i,
  input wire logic usb_clk_ok_i,
  // Watched outputs
  input wire logic txd_o,
  input wire logic channels_on_o,
  input wire logic usb_on_o,
  input wire logic boot_pins_drive_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic periph_reset_o,
  input wire logic irq_disable_o,
  input wire logic jump_zero_o,
  input wire logic remap_o,
  input wire logic too_big_o
);
  localparam logic [31:0] BASE = 32'h0020_0000;
  localparam logic [31:0] LIM = BASE + SRAM_BYTES - 4096;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_gate; $rose(channels_on_o) |-> !boot_valid_i; endproperty
  a_gate: assert property (p_gate) else $error("channels opened after valid boot");
  property p_usb; $rose(usb_on_o) |-> usb_clk_ok_i && channels_on_o; endproperty
  a_usb: assert property (p_usb) else $error("usb started without clock");
  property p_seq;
    $rose(periph_reset_o) |=> $rose(irq_disable_o) ##1 $rose(jump_zero_o) ##1 $rose(remap_o);
  endproperty
  a_seq: assert property (p_seq) else $error("hand-off order broken");
  property p_jump; remap_o |-> jump_zero_o && irq_disable_o && periph_reset_o; endproperty
  a_jump: assert property (p_jump) else $error("remap without jump fetched");
  property p_base; $rose(channels_on_o) |-> mem_addr_o == BASE; endproperty
  a_base: assert property (p_base) else $error("load address not at base");
  property p_big; mem_we_o |-> !too_big_o; endproperty
  a_big: assert property (p_big) else $error("write after size limit");
  property p_lim; mem_we_o |-> mem_addr_o >= BASE && mem_addr_o < LIM; endproperty
  a_lim: assert property (p_lim) else $error("write outside image area");
  property p_idle; !channels_on_o |-> txd_o; endproperty
  a_idle: assert property (p_idle) else $error("serial line not idle high");
  property p_pins; boot_pins_drive_o |-> !channels_on_o && !boot_valid_i; endproperty
  a_pins: assert property (p_pins) else $error("pins driven out of window");
endmodule
bind serial_image_uploader serial_image_uploader_chk #(.SRAM_BYTES(SRAM_BYTES)) i_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .boot_valid_i(boot_valid_i),
  .usb_clk_ok_i(usb_clk_ok_i), .txd_o(txd_o), .channels_on_o(channels_on_o),
  .usb_on_o(usb_on_o), .boot_pins_drive_o(boot_pins_drive_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .periph_reset_o(periph_reset_o), .irq_disable_o(irq_disable_o),
  .jump_zero_o(jump_zero_o), .remap_o(remap_o), .too_big_o(too_big_o));
`default_nettype wire

// *** verif/xmodem_host.sv ***
/* Host terminal model: CRC Xmodem sender and 8N1 byte receiver.
   Assumes its caller starts sends at a falling clock edge. */
`timescale 1ns/1ps
`default_nettype none
module xmodem_host #(parameter integer BIT_CYCLES = 8) (
  input wire logic sys_clk_i,
  input wire logic rxd_i,
  output logic txd_o
);
  logic [7:0] got[$];
  initial txd_o = 1'h1;
  task automatic bit_out(input logic b);
    txd_o = b;
    repeat (BIT_CYCLES) @(negedge sys_clk_i);
  endtask
  task automatic send_byte(input logic [7:0] b);
    bit_out(1'h0);
    for (int i = 0; i < 8; i++) bit_out(b[i]);
    bit_out(1'h1);
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    c ^= {d, 8'h00};
    for (int k = 0; k < 8; k++) c = {c[14:0], 1'h0} ^ (c[15] ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  // Complement and a CRC flip mask passed in so a scenario can corrupt them
  task automatic send_block(input logic [7:0] num, input logic [7:0] cmp,
                            input logic [7:0] seed, input logic [15:0] flip);
    logic [15:0] crc;
    crc = 16'h0000;
    send_byte(8'h01);
    send_byte(num);
    send_byte(cmp);
    for (int i = 0; i < 128; i++) begin
      send_byte(seed + i[7:0]);
      crc = crc16(crc, seed + i[7:0]);
    end
    crc ^= flip;
    send_byte(crc[15:8]);
    send_byte(crc[7:0]);
  endtask
  // Free-running decoder: replies may start before our stop bit ends
  initial forever begin : rx_loop
    logic [7:0] b;
    @(negedge rxd_i);
    repeat (BIT_CYCLES / 2) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge sys_clk_i);
      b[i] = rxd_i;
    end
    repeat (BIT_CYCLES) @(posedge sys_clk_i);
    got.push_back(b);
  end
endmodule
`default_nettype wire

// *** verif/serial_image_uploader_tb.sv ***
/* Testbench for serial_image_uploader: serial Xmodem and USB uploads.
   Assumes xmodem_host on the serial line and a stalling SRAM model here. */
`timescale 1ns/1ps
`default_nettype none
module serial_image_uploader_tb;
  logic sys_clk_i = 0, rst_i = 1, boot_done_i = 0, boot_valid_i = 0, usb_clk_ok_i = 0;
  logic usb_valid_i = 0, usb_last_i = 0, usb_host_reset_i = 0, mem_ready_i = 0, stall = 0;
  logic [1:0] usb_phase_i = 0;
  logic [7:0] usb_data_i = 0;
  wire rxd_i, txd_o, usb_ready_o, usb_manifest_done_o, mem_we_o, boot_pins_drive_o;
  wire channels_on_o, usb_on_o, periph_reset_o, irq_disable_o, remap_o, jump_zero_o, too_big_o;
  wire [31:0] mem_addr_o;
  wire [7:0] mem_data_o;
  int n_fail = 0, total_checks = 0, cyc = 0;
  logic [39:0] expq[$];
  // Limit lands after one block so the size cut is reachable in time
  serial_image_uploader #(.BIT_CYCLES(8), .PIN_DRIVE_CYCLES(50), .SRAM_BYTES(4224)) i_dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .boot_done_i(boot_done_i),
    .boot_valid_i(boot_valid_i), .usb_clk_ok_i(usb_clk_ok_i), .rxd_i(rxd_i), .txd_o(txd_o),
    .usb_phase_i(usb_phase_i), .usb_valid_i(usb_valid_i), .usb_data_i(usb_data_i),
    .usb_ready_o(usb_ready_o), .usb_last_i(usb_last_i),
    .usb_manifest_done_o(usb_manifest_done_o), .usb_host_reset_i(usb_host_reset_i),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
    .mem_ready_i(mem_ready_i), .boot_pins_drive_o(boot_pins_drive_o),
    .channels_on_o(channels_on_o), .usb_on_o(usb_on_o), .periph_reset_o(periph_reset_o),
    .irq_disable_o(irq_disable_o), .remap_o(remap_o), .jump_zero_o(jump_zero_o),
    .too_big_o(too_big_o));
  xmodem_host #(.BIT_CYCLES(8)) i_host (.sys_clk_i(sys_clk_i), .rxd_i(txd_o), .txd_o(rxd_i));
  always #12.5 sys_clk_i = ~sys_clk_i;
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // SRAM accepts one cycle in four and none while stall is set, so writes back up in the buffer
  always @(negedge sys_clk_i) mem_ready_i <= !stall && cyc[1:0] == 2'h3;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      tally_and_finish();
    end
    if (mem_we_o === 1'h1 && mem_ready_i === 1'h1)
      check({mem_addr_o, mem_data_o}, expq.size() ? expq.pop_front() : 40'hX);
  end
  task automatic do_reset();
    @(negedge sys_clk_i);
    rst_i = 1;
    boot_done_i = 0;
    usb_clk_ok_i = 0;
    usb_host_reset_i = 0;
    usb_phase_i = 0;
    repeat (6) @(negedge sys_clk_i);
    rst_i = 0;
  endtask
  task automatic expect_byte(input logic [7:0] exp);
    for (int n = 0; n < 20000 && i_host.got.size() == 0; n++) @(negedge sys_clk_i);
    check(i_host.got.size() ? i_host.got.pop_front() : 8'hXX, exp);
  endtask
  task automatic t_valid_boot();
    do_reset();
    boot_done_i = 1;
    boot_valid_i = 1;
    usb_clk_ok_i = 1;
    repeat (200) @(negedge sys_clk_i);
    check(channels_on_o, 0);
    check(usb_on_o, 0);
    check(boot_pins_drive_o, 0);
    boot_valid_i = 0;
  endtask
  task automatic t_serial();
    int n;
    do_reset();
    boot_done_i = 1;
    for (n = 0; n < 100 && boot_pins_drive_o !== 1'h1; n++) @(negedge sys_clk_i);
    for (n = 0; n < 300 && boot_pins_drive_o === 1'h1; n++) @(negedge sys_clk_i);
    check(n inside {[49:51]}, 1);
    repeat (2) @(negedge sys_clk_i);
    check(channels_on_o, 1);
    check(usb_on_o, 0);
    expect_byte(8'h43);
    i_host.send_byte(8'h04);
    repeat (200) @(negedge sys_clk_i);
    check(i_host.got.size() + remap_o, 0);
    for (int i = 0; i < 128; i++) expq.push_back({32'h0020_0000 + i, 8'h10 + i[7:0]});
    i_host.send_block(8'h01, 8'hFE, 8'h10, 16'h0000);
    expect_byte(8'h06);
    i_host.send_block(8'h03, 8'hFC, 8'h50, 16'h0000);
    expect_byte(8'h15);
    i_host.send_block(8'h02, 8'hFE, 8'h50, 16'h0000);
    expect_byte(8'h15);
    i_host.send_block(8'h02, 8'hFD, 8'h50, 16'h0100);
    expect_byte(8'h15);
    // Deliberately oversized image: sender side limit broken on purpose
    i_host.send_block(8'h02, 8'hFD, 8'h50, 16'h0000);
    expect_byte(8'h06);
    check(too_big_o, 1);
    i_host.send_byte(8'h04);
    expect_byte(8'h06);
    for (n = 0; n < 300 && remap_o !== 1'h1; n++) @(negedge sys_clk_i);
    check({periph_reset_o, irq_disable_o, jump_zero_o, remap_o}, 4'hF);
    check(expq.size(), 0);
  endtask
  task automatic t_usb();
    int k;
    do_reset();
    boot_done_i = 1;
    usb_clk_ok_i = 1;
    for (int n = 0; n < 400 && usb_on_o !== 1'h1; n++) @(negedge sys_clk_i);
    check(usb_on_o, 1);
    for (int p = 0; p < 3; p++) begin
      usb_phase_i = p[1:0];
      repeat (4) @(negedge sys_clk_i);
    end
    stall = 1;
    k = 0;
    usb_valid_i = 1;
    for (int n = 0; n < 9; n++) begin
      usb_last_i = (n == 8);
      if (n == 8) stall = 0;
      usb_data_i = 8'hA0 + k[7:0];
      for (int w = 0; w < 50 && usb_ready_o !== 1'h1 && n == 8; w++) @(negedge sys_clk_i);
      @(posedge sys_clk_i);
      if (usb_ready_o === 1'h1) begin
        expq.push_back({32'h0020_0000 + k, 8'hA0 + k[7:0]});
        k++;
      end
      @(negedge sys_clk_i);
      if (n == 7) check(usb_ready_o, 0);
    end
    usb_valid_i = 0;
    usb_last_i = 0;
    check(k inside {[3:9]}, 1);
    repeat (100) @(negedge sys_clk_i);
    check(expq.size(), 0);
    usb_phase_i = 2'h3;
    for (int n = 0; n < 300 && usb_manifest_done_o !== 1'h1; n++) @(negedge sys_clk_i);
    check(usb_manifest_done_o, 1);
    usb_host_reset_i = 1;
    for (int n = 0; n < 300 && remap_o !== 1'h1; n++) @(negedge sys_clk_i);
    check(remap_o, 1);
  endtask
  initial begin
    t_valid_boot();
    t_serial();
    t_usb();
    tally_and_finish();
  end
endmodule
`default_nettype wire
